//--- hw/cdc_codec_end.sv
// Codec end of the slot link: bit clock generation, ADC/DAC slot words,
// data-valid divider per channel and slot 0/1 register programming.
// Assumes the host changes din after the bit clock rises.
`timescale 1ns/1ps
module cdc_codec_end
   import cdc_pkg::*;
#(
   parameter int HALF_CYC = BCLK_HALF_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   cdc_link_if.codec link,
   input wire logic addr_select_low_i,
   input wire logic addr_select_high_i,
   input wire logic two_wire_sel_i,
   input wire logic [1:0][14:0] adc_sample_i,
   output logic [1:0] adc_take_o,
   output logic [1:0][15:0] dac_word_o,
   output logic [1:0] dac_stb_o,
   output logic [1:0] mode2_o
);
   // din must cross both synchronisers within one bit: three core cycles per phase
   if (HALF_CYC < 3 || HALF_CYC > 256) begin : g_bad_half
      $error("HALF_CYC must lie in 3 to 256");
   end

   logic [7:0] regs [1:REG_COUNT];
   logic [7:0] div_cnt;
   logic bclk_q;
   logic rise;
   logic [5:0] pos;
   logic [5:0] next_pos;
   logic [1:0] din_sync;
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic din_s;
   logic [15:0] rx_sh;
   logic [15:0] rx_word;
   logic [15:0] tx_sh;
   logic [15:0] tx_word;
   logic dout_q;
   logic fs_q;
   logic slot_end;
   logic frame_start;
   logic cmd_hit;
   logic hit_q;
   logic wr_q;
   logic [7:0] addr_q;
   logic [1:0] fresh;
   logic [1:0] compand;
   logic flag_en;
   logic mode2;
   logic [7:0] rd_byte;

   // Bit clock from core clock; 8 core cycles per bit at default
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= 8'h00;
         bclk_q <= 1'b0;
      end else if (div_cnt == 8'(HALF_CYC - 1)) begin
         div_cnt <= 8'h00;
         bclk_q <= ~bclk_q;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign rise = (div_cnt == 8'(HALF_CYC - 1)) && !bclk_q;
   assign next_pos = (pos == POS_LAST) ? 6'h00 : pos + 6'h01;
   assign frame_start = rise && (next_pos == 6'h00);
   assign slot_end = rise && (pos[3:0] == BIT_LAST);

   // Pins from the other party are synchronised before use
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         din_sync <= 2'h0;
         pin_s1 <= 3'h0;
         pin_s2 <= 3'h0;
      end else begin
         din_sync <= {din_sync[0], link.din};
         pin_s1 <= {two_wire_sel_i, addr_select_high_i, addr_select_low_i};
         pin_s2 <= pin_s1;
      end
   end
   assign din_s = din_sync[1];

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pos <= POS_LAST;
         rx_sh <= 16'h0000;
      end else if (rise) begin
         pos <= next_pos;
         rx_sh <= rx_word;
      end
   end
   // Bit driven at the previous rise is sampled now, a full bit later
   assign rx_word = {rx_sh[14:0], din_s};

   assign mode2 = regs[REG_CLK][6:4] >= MODE2_LO;
   assign flag_en = regs[REG_FLAG][FLAG_EN_BIT];
   assign compand[0] = |regs[REG_C1_FMT][1:0];
   assign compand[1] = |regs[REG_C2_FMT][1:0];
   assign mode2_o = {mode2, mode2};

   // Slot 0 decode, valid only when pos ends slot 0
   assign cmd_hit = !pin_s2[2]
      && (rx_word[CMD_DEV_LO +: 2] == pin_s2[1:0])
      && (rx_word[CMD_ADDR_LO +: 8] != 8'h00)
      && (rx_word[CMD_ADDR_LO +: 8] <= 8'(REG_COUNT));
   assign rd_byte = regs[rx_word[CMD_ADDR_LO +: 8]];

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hit_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 8'h00;
      end else if (slot_end && pos[5:4] == SLOT_CMD) begin
         hit_q <= cmd_hit;
         wr_q <= rx_word[CMD_RW];
         addr_q <= rx_word[CMD_ADDR_LO +: 8];
      end
   end

   // Register file, reached only through slots 0 and 1 here
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int r = 1; r <= REG_COUNT; r++) begin
            regs[r] <= RST_OTHER;
         end
         regs[REG_C1_DN] <= RST_DN;
         regs[REG_C2_DN] <= RST_DN;
         regs[REG_C1_I] <= RST_I;
         regs[REG_C2_I] <= RST_I;
         regs[REG_FLAG] <= RST_FLAG;
      end else if (slot_end && pos[5:4] == SLOT_DATA && hit_q && wr_q) begin
         regs[addr_q] <= rx_word[15:8];
      end
   end

   // Per-channel fractional divider on frame syncs
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_div
         logic [4:0] fcnt;
         logic [4:0] len;
         logic [3:0] acc;
         logic [4:0] i_val;
         logic [4:0] d_val;
         logic [4:0] sum;
         logic carry;
         logic [7:0] dn_reg;
         logic [7:0] i_reg;
         assign dn_reg = (ch == 0) ? regs[REG_C1_DN] : regs[REG_C2_DN];
         assign i_reg = (ch == 0) ? regs[REG_C1_I] : regs[REG_C2_I];
         assign i_val = {1'b0, i_reg[7:4]} + 5'h01;
         assign d_val = {1'b0, dn_reg[7:4]} + 5'h01;
         assign sum = {1'b0, acc} + {1'b0, dn_reg[3:0]};
         assign carry = sum >= d_val;
         always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               fcnt <= 5'h00;
               len <= 5'h01;
               acc <= 4'h0;
               fresh[ch] <= 1'b0;
            end else if (frame_start) begin
               if (!mode2) begin
                  fresh[ch] <= 1'b1;
                  fcnt <= 5'h00;
               end else if (fcnt + 5'h01 >= len) begin
                  // Interval of I or I+1 frames, per channel
                  fresh[ch] <= 1'b1;
                  fcnt <= 5'h00;
                  acc <= carry ? 4'(sum - d_val) : sum[3:0];
                  len <= i_val + {4'h0, carry};
               end else begin
                  fresh[ch] <= 1'b0;
                  fcnt <= fcnt + 5'h01;
               end
            end
         end
      end
   endgenerate

   // Word for the slot whose first bit is driven at this rise
   always_comb begin
      tx_word = 16'h0000;
      case (next_pos[5:4])
         SLOT_DATA: begin
            if (cmd_hit && !rx_word[CMD_RW]) begin
               tx_word = {rd_byte, 8'h00};
            end
         end
         SLOT_CH0, SLOT_CH1: begin
            tx_word[15] = fresh[next_pos[4]] && flag_en;
            if (compand[next_pos[4]]) begin
               tx_word[14:0] = {7'h00, adc_sample_i[next_pos[4]][7:0]};
            end else begin
               tx_word[14:0] = adc_sample_i[next_pos[4]];
            end
         end
         default: tx_word = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_sh <= 16'h0000;
         dout_q <= 1'b0;
         fs_q <= 1'b0;
         adc_take_o <= 2'h0;
      end else begin
         adc_take_o <= 2'h0;
         if (rise) begin
            fs_q <= next_pos == 6'h00;
            if (next_pos[3:0] == 4'h0) begin
               dout_q <= tx_word[15];
               tx_sh <= {tx_word[14:0], 1'b0};
               if (next_pos[5] && tx_word[15]) begin
                  adc_take_o[next_pos[4]] <= 1'b1;
               end
            end else begin
               dout_q <= tx_sh[15];
               tx_sh <= {tx_sh[14:0], 1'b0};
            end
         end
      end
   end

   // DAC words carry no flag; every frame delivers one per channel
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dac_word_o <= '0;
         dac_stb_o <= 2'h0;
      end else begin
         dac_stb_o <= 2'h0;
         if (slot_end && pos[5]) begin
            dac_stb_o[pos[4]] <= 1'b1;
            if (compand[pos[4]]) begin
               dac_word_o[pos[4]] <= {8'h00, rx_word[7:0]};
            end else begin
               dac_word_o[pos[4]] <= rx_word;
            end
         end
      end
   end

   assign link.bclk = bclk_q;
   assign link.frame_sync = fs_q;
   assign link.dout = dout_q;
endmodule // cdc_codec_end

//--- common/cdc_pkg.sv
// Shared constants of the codec slot link: frame layout, register map,
// reset values and divider clocking. Used by both link ends.
package cdc_pkg;
   localparam int SLOT_BITS = 16;
   localparam int SLOTS = 4;
   localparam int FRAME_BITS = SLOT_BITS * SLOTS;
   localparam logic [1:0] SLOT_CMD = 2'h0;
   localparam logic [1:0] SLOT_DATA = 2'h1;
   localparam logic [1:0] SLOT_CH0 = 2'h2;
   localparam logic [1:0] SLOT_CH1 = 2'h3;
   localparam logic [5:0] POS_LAST = 6'h3F;
   localparam logic [3:0] BIT_LAST = 4'hF;
   // Command word fields
   localparam int CMD_RW = 15;
   localparam int CMD_DEV_LO = 13;
   localparam int CMD_ADDR_LO = 5;
   localparam logic [4:0] CMD_PAD = 5'h00;
   // Register map, 8-bit registers at addresses 1..17
   localparam int REG_COUNT = 17;
   localparam logic [7:0] REG_C1_DN = 8'h01;
   localparam logic [7:0] REG_C1_I = 8'h02;
   localparam logic [7:0] REG_C1_FMT = 8'h04;
   localparam logic [7:0] REG_C2_DN = 8'h06;
   localparam logic [7:0] REG_C2_I = 8'h07;
   localparam logic [7:0] REG_C2_FMT = 8'h09;
   localparam logic [7:0] REG_CLK = 8'h0C;
   localparam logic [7:0] REG_FLAG = 8'h0D;
   localparam logic [7:0] RST_DN = 8'h50;
   localparam logic [7:0] RST_I = 8'h50;
   localparam logic [7:0] RST_FLAG = 8'h01;
   localparam logic [7:0] RST_OTHER = 8'h00;
   localparam int FLAG_EN_BIT = 0;
   localparam logic [2:0] MODE2_LO = 3'h5;
   // Bit clock half period in core cycles (8 ns each)
   localparam int BCLK_HALF_CYC = 4;
endpackage

//--- common/cdc_link_if.sv
// Serial slot link between the codec end and the host end.
// The codec end makes the bit clock and frame sync; no tri-state pins.
`timescale 1ns/1ps
interface cdc_link_if;
   logic bclk;
   logic frame_sync;
   logic din;
   logic dout;
   modport codec (output bclk, output frame_sync, output dout, input din);
   modport host (input bclk, input frame_sync, input dout, output din);
endinterface : cdc_link_if

//--- hw/cdc_host_end.sv
// Host end of the slot link: collects flagged ADC words, answers flags
// with DAC words and carries register commands in slots 0 and 1.
// Assumes the codec end makes the bit clock and frame sync.
`timescale 1ns/1ps
module cdc_host_end
   import cdc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   cdc_link_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic [1:0] cmd_dev_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic [1:0] adc_valid_o,
   output logic [1:0][14:0] adc_word_o,
   output logic [1:0] dac_req_o,
   input wire logic [1:0][15:0] dac_word_i
);
   logic [2:0] s1;
   logic [2:0] s2;
   logic bclk_d;
   logic rise;
   logic [5:0] pos;
   logic [5:0] next_pos;
   logic [15:0] rx_sh;
   logic [15:0] rx_word;
   logic [15:0] tx_sh;
   logic [15:0] tx_word;
   logic din_q;
   logic held_v;
   logic held_wr;
   logic [1:0] held_dev;
   logic [7:0] held_addr;
   logic [7:0] held_data;
   logic act_v;
   logic act_wr;
   logic [7:0] act_data;
   logic [1:0] dac_pend;
   logic [1:0] dac_send;
   logic [1:0][15:0] dac_hold;

   // Link pins come from the other party: two flip-flops first
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         bclk_d <= 1'b0;
      end else begin
         s1 <= {link.dout, link.frame_sync, link.bclk};
         s2 <= s1;
         bclk_d <= s2[0];
      end
   end
   assign rise = s2[0] && !bclk_d;
   assign next_pos = s2[1] ? 6'h00 : pos + 6'h01;
   assign rx_word = {rx_sh[14:0], s2[2]};
   assign cmd_ready_o = !held_v;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pos <= POS_LAST;
         rx_sh <= 16'h0000;
      end else if (rise) begin
         pos <= next_pos;
         rx_sh <= rx_word;
      end
   end

   always_comb begin
      tx_word = 16'h0000;
      case (next_pos[5:4])
         SLOT_CMD: begin
            if (held_v) begin
               tx_word = {held_wr, held_dev, held_addr, CMD_PAD};
            end
         end
         SLOT_DATA: begin
            if (act_v && act_wr) begin
               tx_word = {act_data, 8'h00};
            end
         end
         default: begin
            if (dac_send[next_pos[4]]) begin
               tx_word = dac_hold[next_pos[4]];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         held_v <= 1'b0;
         held_wr <= 1'b0;
         held_dev <= 2'h0;
         held_addr <= 8'h00;
         held_data <= 8'h00;
         act_v <= 1'b0;
         act_wr <= 1'b0;
         act_data <= 8'h00;
      end else begin
         if (rise && next_pos == 6'h00) begin
            act_v <= held_v;
            act_wr <= held_wr;
            act_data <= held_data;
            held_v <= 1'b0;
         end else if (rise && next_pos == 6'h1F) begin
            act_v <= 1'b0;
         end
         // Accept wins over the frame-start drain of the same cycle
         if (cmd_valid_i && !held_v) begin
            held_v <= 1'b1;
            held_wr <= cmd_write_i;
            held_dev <= cmd_dev_i;
            held_addr <= cmd_addr_i;
            held_data <= cmd_data_i;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         din_q <= 1'b0;
         tx_sh <= 16'h0000;
         rd_valid_o <= 1'b0;
         rd_data_o <= 8'h00;
         adc_valid_o <= 2'h0;
         adc_word_o <= '0;
         dac_req_o <= 2'h0;
         dac_pend <= 2'h0;
         dac_send <= 2'h0;
         dac_hold <= '0;
      end else begin
         rd_valid_o <= 1'b0;
         adc_valid_o <= 2'h0;
         dac_req_o <= 2'h0;
         if (rise) begin
            if (next_pos[3:0] == 4'h0) begin
               din_q <= tx_word[15];
               tx_sh <= {tx_word[14:0], 1'b0};
            end else begin
               din_q <= tx_sh[15];
               tx_sh <= {tx_sh[14:0], 1'b0};
            end
            if (next_pos == 6'h00) begin
               dac_send <= dac_pend;
               dac_hold <= dac_word_i;
               dac_pend <= 2'h0;
            end
            if (next_pos == 6'h1F && act_v && !act_wr) begin
               rd_valid_o <= 1'b1;
               rd_data_o <= rx_word[15:8];
            end
            // Every channel slot is read; unflagged words are dropped
            if (next_pos[5] && next_pos[3:0] == BIT_LAST && rx_word[15]) begin
               adc_valid_o[next_pos[4]] <= 1'b1;
               adc_word_o[next_pos[4]] <= rx_word[14:0];
               dac_req_o[next_pos[4]] <= 1'b1;
               dac_pend[next_pos[4]] <= 1'b1;
            end
         end
      end
   end

   assign link.din = din_q;
endmodule // cdc_host_end

//--- bench/cdc_link_props.sv
// Checker of the slot link wire: bit clock, framing and slot zero fields.
// Assumes the default bit clock divider and both link ends as design code.
`timescale 1ns/1ps
module cdc_link_props
   import cdc_pkg::*;
#(
   parameter int HALF_CYC = BCLK_HALF_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic bclk,
   input wire logic frame_sync,
   input wire logic din,
   input wire logic dout
);
   localparam int FRAME_CYC = FRAME_BITS * 2 * HALF_CYC - 1;
   logic bclk_q;
   logic seen;
   logic [5:0] pos;
   logic [15:0] cmd;
   logic [9:0] gap;
   wire logic rise = bclk && !bclk_q;
   wire logic fall = !bclk && bclk_q;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bclk_q <= 1'b0;
      end else begin
         bclk_q <= bclk;
      end
   end
   // Bit index of the frame, valid from the first frame start on
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seen <= 1'b0;
         pos <= POS_LAST;
      end else if (rise) begin
         seen <= seen | frame_sync;
         pos <= frame_sync ? 6'h00 : pos + 6'h01;
      end
   end
   // Slot 0 of din, sampled mid-bit where it is settled
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd <= 16'h0000;
      end else if (fall && pos <= 6'h0F) begin
         cmd <= {cmd[14:0], din};
      end
   end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap <= 10'h000;
      end else begin
         gap <= (rise && frame_sync) ? 10'h000 : gap + 10'h001;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_bclk_high;
      $rose(bclk) |-> bclk[*4] ##1 !bclk;
   endproperty
   a_bclk_high: assert property (p_bclk_high)
      else $error("bit clock high phase has the wrong length");
   property p_fs_width;
      $rose(frame_sync) |-> frame_sync[*8] ##1 !frame_sync;
   endproperty
   a_fs_width: assert property (p_fs_width)
      else $error("frame sync is not one bit wide");
   property p_dout_edge;
      $changed(dout) |-> rise;
   endproperty
   a_dout_edge: assert property (p_dout_edge)
      else $error("dout moved away from a bit clock rise");
   property p_frame_len;
      rise && frame_sync && seen |-> gap == FRAME_CYC;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame is not sixty-four bits long");
   property p_slot0_zero;
      fall && seen && pos <= 6'h0F |-> !dout;
   endproperty
   a_slot0_zero: assert property (p_slot0_zero)
      else $error("dout slot 0 is not zero");
   property p_wr_zero;
      fall && seen && pos[5:4] == SLOT_DATA && cmd[CMD_RW] |-> !dout;
   endproperty
   a_wr_zero: assert property (p_wr_zero)
      else $error("dout slot 1 not zero during a write");
   property p_din_pad;
      fall && seen && pos >= 6'h0B && pos <= 6'h0F |-> !din;
   endproperty
   a_din_pad: assert property (p_din_pad)
      else $error("din slot 0 pad bits not zero");
   property p_din_slot1;
      fall && seen && pos[5:4] == SLOT_DATA && (pos[3] || !cmd[CMD_RW])
         |-> !din;
   endproperty
   a_din_slot1: assert property (p_din_slot1)
      else $error("din slot 1 carries bits that must be zero");
endmodule // cdc_link_props

//--- bench/cdc_codec_slot_bench.sv
// Bench of the slot link: codec end and host end face each other.
// Assumes the default bit clock divider; inputs move on falling edges.
`timescale 1ns/1ps
module cdc_codec_slot_bench
   import cdc_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b0;
   logic two_wire = 1'b0;
   logic [1:0][14:0] adc_in = '0;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [1:0] cmd_dev = 2'h0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_data = 8'h00;
   logic [1:0][15:0] dac_in = '0;
   logic cmd_ready;
   logic rd_valid;
   logic [7:0] rd_data;
   logic [1:0] mode2;
   logic [1:0] dac_stb;
   logic [1:0] adc_valid;
   logic [1:0] adc_take;
   logic [1:0] dac_req;
   logic [1:0][15:0] dac_out;
   logic [1:0][14:0] adc_word;
   logic [7:0] v;
   int bad_count = 0;
   int checks_done = 0;
   always #4 core_clk_i = ~core_clk_i;
   cdc_link_if link_if ();
   cdc_codec_end i_cdc_codec_end (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link(link_if), .addr_select_low_i(sel_lo), .addr_select_high_i(sel_hi),
      .two_wire_sel_i(two_wire), .adc_sample_i(adc_in), .adc_take_o(adc_take),
      .dac_word_o(dac_out), .dac_stb_o(dac_stb), .mode2_o(mode2));
   cdc_host_end i_cdc_host_end (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .link(link_if), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
      .cmd_write_i(cmd_write), .cmd_dev_i(cmd_dev), .cmd_addr_i(cmd_addr),
      .cmd_data_i(cmd_data), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
      .adc_valid_o(adc_valid), .adc_word_o(adc_word), .dac_req_o(dac_req),
      .dac_word_i(dac_in));
   cdc_link_props i_cdc_link_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .bclk(link_if.bclk), .frame_sync(link_if.frame_sync),
      .din(link_if.din), .dout(link_if.dout));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Ready only drops at an accept, so seeing it at a falling edge is safe
   task automatic send(input logic wr, input logic [1:0] dev,
                       input logic [7:0] addr, input logic [7:0] data);
      @(negedge core_clk_i);
      cmd_write = wr;
      cmd_dev = dev;
      cmd_addr = addr;
      cmd_data = data;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge core_clk_i);
      @(negedge core_clk_i);
      cmd_valid = 1'b0;
   endtask
   task automatic wr(input logic [1:0] dev, input logic [7:0] a,
                     input logic [7:0] d);
      send(1'b1, dev, a, d);
      repeat (2) @(posedge link_if.frame_sync);
      @(negedge core_clk_i);
   endtask
   task automatic rd(input logic [1:0] dev, input logic [7:0] a);
      send(1'b0, dev, a, 8'h00);
      while (rd_valid !== 1'b1) @(negedge core_clk_i);
      v = rd_data;
   endtask
   task automatic t_reset_values();
      check(16'(mode2), 16'h0000);
      rd(2'h0, REG_C1_DN);
      check(16'(v), 16'(RST_DN));
      rd(2'h0, REG_C2_I);
      check(16'(v), 16'(RST_I));
      rd(2'h0, REG_FLAG);
      check(16'(v), 16'(RST_FLAG));
      rd(2'h0, 8'h12);
      check(16'(v), 16'h0000);
   endtask
   task automatic t_regs();
      wr(2'h0, 8'h0F, 8'h23);
      wr(2'h0, 8'h11, 8'hC4);
      rd(2'h0, 8'h0F);
      check(16'(v), 16'h0023);
      rd(2'h0, 8'h11);
      check(16'(v), 16'h00C4);
      wr(2'h1, 8'h0F, 8'h55);
      rd(2'h0, 8'h0F);
      check(16'(v), 16'h0023);
      @(negedge core_clk_i);
      sel_hi = 1'b1;
      wr(2'h2, 8'h0F, 8'h5A);
      rd(2'h2, 8'h0F);
      check(16'(v), 16'h005A);
      sel_hi = 1'b0;
      sel_lo = 1'b1;
      rd(2'h1, 8'h0F);
      check(16'(v), 16'h005A);
      rd(2'h0, 8'h0F);
      check(16'(v), 16'h0000);
      sel_lo = 1'b0;
      two_wire = 1'b1;
      wr(2'h0, 8'h0F, 8'h77);
      two_wire = 1'b0;
      rd(2'h0, 8'h0F);
      check(16'(v), 16'h005A);
   endtask
   // Counts flagged words over four whole frames, one slot each per frame
   task automatic t_flags(input logic [15:0] exp);
      int n0;
      int n1;
      int nt;
      int nr;
      n0 = 0;
      n1 = 0;
      nt = 0;
      nr = 0;
      repeat (4 * 512) begin
         @(negedge core_clk_i);
         n0 += int'(adc_valid[0] === 1'b1);
         n1 += int'(adc_valid[1] === 1'b1);
         nt += int'(adc_take[0] === 1'b1) + int'(adc_take[1] === 1'b1);
         nr += int'(dac_req[0] === 1'b1) + int'(dac_req[1] === 1'b1);
      end
      check(16'(n0), exp);
      check(16'(n1), exp);
      check(16'(nt), exp << 1);
      check(16'(nr), exp << 1);
   endtask
   task automatic t_data();
      adc_in = {15'h1234, 15'h7ABC};
      dac_in = {16'h80A5, 16'h8123};
      t_flags(16'h0004);
      check(16'(adc_word[0]), 16'h7ABC);
      check(16'(adc_word[1]), 16'h1234);
      check(dac_out[0], 16'h8123);
      check(dac_out[1], 16'h80A5);
      wr(2'h0, REG_FLAG, 8'h00);
      t_flags(16'h0000);
      wr(2'h0, REG_FLAG, RST_FLAG);
      wr(2'h0, REG_C1_FMT, 8'h01);
      wr(2'h0, REG_C2_FMT, 8'h02);
      repeat (2) @(posedge link_if.frame_sync);
      @(negedge core_clk_i);
      check(16'(adc_word[0]), 16'h00BC);
      check(16'(adc_word[1]), 16'h0034);
      // Companded DAC slots keep only the low byte
      while (dac_stb[1] !== 1'b1) @(negedge core_clk_i);
      check(dac_out[0], 16'h0023);
      check(dac_out[1], 16'h00A5);
   endtask
   // Four plus four ninths on channel 0, a plain four on channel 1
   task automatic t_divider();
      int fr;
      int l0;
      int l1;
      int n0;
      int n1;
      int sum0;
      int five0;
      int bad1;
      logic fs_q;
      wr(2'h0, REG_C1_DN, 8'h84);
      wr(2'h0, REG_C1_I, 8'h30);
      wr(2'h0, REG_C2_DN, 8'h80);
      wr(2'h0, REG_C2_I, 8'h30);
      wr(2'h0, REG_CLK, 8'h50);
      check(16'(mode2), 16'h0003);
      {fr, l0, l1, n0, n1, sum0, five0, bad1} = '0;
      fs_q = 1'b1;
      repeat (56 * 512) begin
         @(negedge core_clk_i);
         fr += int'(link_if.frame_sync && !fs_q);
         fs_q = link_if.frame_sync;
         if (adc_valid[0] === 1'b1) begin
            if (n0 >= 2 && n0 <= 10) begin
               sum0 += fr - l0;
               five0 += int'(fr - l0 == 5);
            end
            l0 = fr;
            n0++;
         end
         if (adc_valid[1] === 1'b1) begin
            bad1 += int'(n1 >= 2 && fr - l1 != 4);
            l1 = fr;
            n1++;
         end
      end
      check(16'(sum0), 16'd40);
      check(16'(five0), 16'd4);
      check(16'(bad1), 16'd0);
      check(16'(n1 > 10), 16'h0001);
   endtask
   initial begin
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_i = 1'b0;
      t_reset_values();
      t_regs();
      t_data();
      t_divider();
      summarize();
   end
   // Whole run is near 435 us; the margin covers slow command frames
   initial begin
      #760000;
      bad_count++;
      summarize();
   end
endmodule // cdc_codec_slot_bench
